// File: sgc_consts.svh
// offsets, field positions, reset values and timing counts of the global control bank
`ifndef SGC_CONSTS_SVH
`define SGC_CONSTS_SVH

// register offsets
`define SGC_ADDR_FEATURE 8'h05
`define SGC_ADDR_LINK 8'h06
`define SGC_ADDR_STORM_LO 8'h07

// feature control field positions
`define SGC_FEAT_VLAN_BIT 7
`define SGC_FEAT_IGMP_BIT 6
`define SGC_FEAT_SNIFF_BIT 0
// writable bits of feature control, reserved 5..1 stay zero
`define SGC_FEAT_WMASK 8'hC1

// port-five link field positions
`define SGC_LINK_BP_BIT 7
`define SGC_LINK_HALF_BIT 6
`define SGC_LINK_FC_BIT 5
`define SGC_LINK_RATE10_BIT 4
`define SGC_LINK_NULLVID_BIT 3
`define SGC_LINK_STORM_HI_MSB 2

// reset values
`define SGC_FEATURE_RESET 8'h00
`define SGC_LINK_RESET 8'h00
`define SGC_STORM_LO_RESET 8'h4A
`define SGC_STORM_RESET 11'h04A

// widths and counts
`define SGC_PORTS 5
`define SGC_LIMIT_W 11
`define SGC_LIMIT_MAX 11'h7FF
`define SGC_PERIOD_CNT_W 23

// storm period timing
`define SGC_CLK_PERIOD_NS 10
`define SGC_STORM_100_MS 50
`define SGC_STORM_10_MS 500
`define SGC_STORM_100_CYCLES (`SGC_STORM_100_MS * 1000000 / `SGC_CLK_PERIOD_NS)
`define SGC_STORM_RATIO (`SGC_STORM_10_MS / `SGC_STORM_100_MS)

`endif

// File: sgc_global_ctrl.sv
// global control bank: feature enables, port five link settings, storm protection
//
// Behaviour
// - feature bit 7 enables 802.1Q VLAN processing
// - feature bit 6 redirects IGMP to port five
// - feature bit 0: both ports match versus either
// - link bit 7 enables port five back pressure
// - link bit 6 selects half or full duplex
// - link bit 5 enables full-duplex flow control
// - link bit 4 selects 10 or 100 Mbit
// - link bit 3 replaces null VID with default
// - 11-bit storm limit split across two registers
// - storm period 50ms fast, 500ms slow ports
// - storm limit resets to 0x4A
`include "sgc_consts.svh"

module sgc_global_ctrl #(
	parameter int PERIOD_100_CYCLES = `SGC_STORM_100_CYCLES
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic reset_i,
	// register port
	input wire sgc_pkg::sgc_reg_req_t reg_req_i,
	output logic [7:0] reg_rdata_o,
	output logic reg_rvalid_o,
	// control levels to the switch core
	output sgc_pkg::sgc_feature_t feature_o,
	output sgc_pkg::sgc_port5_mac_link_t port5_mac_link_o,
	output logic [`SGC_LIMIT_W-1:0] storm_limit_o,
	// storm protection per input port, index 4 is port five
	input wire logic [`SGC_PORTS-1:0] storm_block_i,
	input wire logic [`SGC_PORTS-2:0] port_rate_10_mbit_i,
	output logic [`SGC_PORTS-1:0] storm_drop_o
);
	import sgc_pkg::*;

	localparam logic [`SGC_PERIOD_CNT_W-1:0] PERIOD_LAST =
		`SGC_PERIOD_CNT_W'(PERIOD_100_CYCLES - 1);
	localparam logic [3:0] RATIO_LAST = 4'(`SGC_STORM_RATIO - 1);

	logic [7:0] feature_reg; // feature control register
	logic [7:0] link_reg; // port five link and storm high bits
	logic [7:0] storm_lo_reg; // storm limit low byte
	logic [7:0] rdata_reg; // read data holding register
	logic rvalid_reg; // read answer strobe
	logic [`SGC_PERIOD_CNT_W-1:0] period_cnt_reg; // fast period divider
	logic [3:0] decade_reg; // counts fast periods into a slow one
	logic tick_100; // end of a 50 ms period
	logic tick_10; // end of a 500 ms period
	logic [`SGC_PORTS-1:0] port_rate_10; // speed of each port
	logic [`SGC_PORTS-1:0] port_tick; // period end seen by each port
	logic wr_feature;
	logic wr_link;
	logic wr_storm_lo;

	// register read decode, unmapped offsets read zero
	function automatic logic [7:0] reg_value(input logic [7:0] addr,
		input logic [7:0] feat, input logic [7:0] link, input logic [7:0] lo);
		logic [7:0] v;
		v = 8'h00;
		unique case (addr)
			`SGC_ADDR_FEATURE: v = feat;
			`SGC_ADDR_LINK: v = link;
			`SGC_ADDR_STORM_LO: v = lo;
			default: v = 8'h00;
		endcase
		return v;
	endfunction

	// write strobes per register
	assign wr_feature = reg_req_i.wr && reg_req_i.addr == `SGC_ADDR_FEATURE;
	assign wr_link = reg_req_i.wr && reg_req_i.addr == `SGC_ADDR_LINK;
	assign wr_storm_lo = reg_req_i.wr && reg_req_i.addr == `SGC_ADDR_STORM_LO;

	// feature control register, reserved bits held at zero
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			feature_reg <= `SGC_FEATURE_RESET;
		end else if (wr_feature) begin
			feature_reg <= reg_req_i.wdata & `SGC_FEAT_WMASK;
		end
	end

	// port five link register with storm limit high bits
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			link_reg <= `SGC_LINK_RESET;
		end else if (wr_link) begin
			link_reg <= reg_req_i.wdata;
		end
	end

	// storm limit low byte
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			storm_lo_reg <= `SGC_STORM_LO_RESET;
		end else if (wr_storm_lo) begin
			storm_lo_reg <= reg_req_i.wdata;
		end
	end

	// read answer one cycle after the request
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			rdata_reg <= 8'h00;
			rvalid_reg <= 1'b0;
		end else begin
			rvalid_reg <= reg_req_i.rd;
			if (reg_req_i.rd) begin
				rdata_reg <= reg_value(reg_req_i.addr, feature_reg, link_reg, storm_lo_reg);
			end
		end
	end

	assign reg_rdata_o = rdata_reg;
	assign reg_rvalid_o = rvalid_reg;

	// control levels straight from the registers
	// vlan enable assumes the table is already loaded by software
	assign feature_o.vlan_en = feature_reg[`SGC_FEAT_VLAN_BIT];
	assign feature_o.igmp_snoop = feature_reg[`SGC_FEAT_IGMP_BIT];
	assign feature_o.sniff_both = feature_reg[`SGC_FEAT_SNIFF_BIT];
	assign port5_mac_link_o.back_pressure = link_reg[`SGC_LINK_BP_BIT];
	assign port5_mac_link_o.half_duplex = link_reg[`SGC_LINK_HALF_BIT];
	assign port5_mac_link_o.flow_ctrl = link_reg[`SGC_LINK_FC_BIT];
	assign port5_mac_link_o.rate_10_mbit = link_reg[`SGC_LINK_RATE10_BIT];
	assign port5_mac_link_o.null_vid_replace = link_reg[`SGC_LINK_NULLVID_BIT];
	assign storm_limit_o = {link_reg[`SGC_LINK_STORM_HI_MSB:0], storm_lo_reg};

	// fast period divider, one tick each 50 ms
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			period_cnt_reg <= '0;
		end else if (period_cnt_reg == PERIOD_LAST) begin
			period_cnt_reg <= '0;
		end else begin
			period_cnt_reg <= period_cnt_reg + `SGC_PERIOD_CNT_W'(1);
		end
	end

	assign tick_100 = (period_cnt_reg == PERIOD_LAST);

	// slow period: ten fast periods make 500 ms
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			decade_reg <= 4'h0;
		end else if (tick_100) begin
			decade_reg <= (decade_reg == RATIO_LAST) ? 4'h0 : decade_reg + 4'h1;
		end
	end

	assign tick_10 = tick_100 && (decade_reg == RATIO_LAST);

	// port five takes its speed from the link register
	assign port_rate_10 = {link_reg[`SGC_LINK_RATE10_BIT], port_rate_10_mbit_i};

	// one storm meter per input port
	for (genvar p = 0; p < `SGC_PORTS; p++) begin : g_meter
		assign port_tick[p] = port_rate_10[p] ? tick_10 : tick_100;
		sgc_storm_meter u_meter (
			.clock_i(clock_i),
			.reset_i(reset_i),
			.period_tick_i(port_tick[p]),
			.block_i(storm_block_i[p]),
			.limit_i(storm_limit_o),
			.drop_o(storm_drop_o[p])
		);
	end

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (reset_i);

	sequence s_feat_write;
		reg_req_i.wr && reg_req_i.addr == `SGC_ADDR_FEATURE;
	endsequence

	sequence s_link_write;
		reg_req_i.wr && reg_req_i.addr == `SGC_ADDR_LINK;
	endsequence

	a_vlan_enable: assert property (
		s_feat_write |=> feature_o.vlan_en == $past(reg_req_i.wdata[7]))
		else $error("vlan enable does not follow write");

	a_igmp_snoop: assert property (
		s_feat_write |=> feature_o.igmp_snoop == $past(reg_req_i.wdata[6])
		&& feature_reg[5:1] == 5'h00)
		else $error("igmp snoop does not follow write");

	a_sniff_mode: assert property (
		s_feat_write ##1 !reg_req_i.wr |=> feature_o.sniff_both == $past(reg_req_i.wdata[0], 2))
		else $error("sniff mode lost");

	a_link_bits: assert property (
		s_link_write |=> port5_mac_link_o.back_pressure == $past(reg_req_i.wdata[7])
		&& port5_mac_link_o.half_duplex == $past(reg_req_i.wdata[6]))
		else $error("back pressure or duplex wrong");

	a_duplex_hold: assert property (
		!wr_link |=> $stable(port5_mac_link_o.half_duplex))
		else $error("duplex changed without write");

	a_flow_ctrl: assert property (
		s_link_write |=> port5_mac_link_o.flow_ctrl == $past(reg_req_i.wdata[5]))
		else $error("flow control does not follow write");

	a_port5_speed: assert property (
		s_link_write |=> port5_mac_link_o.rate_10_mbit == $past(reg_req_i.wdata[4])
		&& port_tick[4] == ($past(reg_req_i.wdata[4]) ? tick_10 : tick_100))
		else $error("port five speed wrong");

	a_null_vid: assert property (
		s_link_write |=> port5_mac_link_o.null_vid_replace == $past(reg_req_i.wdata[3]))
		else $error("null vid replace does not follow write");

	a_storm_split: assert property (
		(s_link_write and !wr_storm_lo) |=> storm_limit_o[10:8] == $past(reg_req_i.wdata[2:0])
		&& $stable(storm_limit_o[7:0]))
		else $error("storm limit high bits wrong");

	a_slow_period: assert property (
		tick_10 |-> tick_100 && decade_reg == RATIO_LAST ##1 decade_reg == 4'h0)
		else $error("slow period not ten fast periods");

	a_reset_limit: assert property (
		$past(reset_i) |-> storm_limit_o == `SGC_STORM_RESET)
		else $error("storm limit reset value wrong");

	a_read_answer: assert property (
		reg_req_i.rd && reg_req_i.addr == `SGC_ADDR_STORM_LO && !reg_req_i.wr
		|=> reg_rvalid_o && reg_rdata_o == storm_lo_reg)
		else $error("storm low byte read wrong");
endmodule

// File: sgc_global_ctrl_test.sv
// self-checking bench for the global control bank: registers, link settings, storm meters
`include "sgc_consts.svh"

module sgc_global_ctrl_test;
	timeunit 1ns;
	timeprecision 1ps;
	import sgc_pkg::*;

	localparam int PERIOD = 20; // short fast storm period, slow one is ten times longer
	logic clock_i = 1'b0; // bench clock
	logic reset_i = 1'b1; // synchronous reset
	sgc_reg_req_t reg_req = '0; // register request
	logic [4:0] blocks = '0; // storm block pulses
	logic [3:0] rates = '0; // ports one to four at 10 Mbit
	logic [7:0] reg_rdata; // read data
	logic reg_rvalid; // read answer strobe
	sgc_feature_t feature; // feature enables
	sgc_port5_mac_link_t link; // port five link settings
	logic [10:0] limit; // storm limit
	logic [4:0] drop; // storm discard per port
	logic [7:0] exp_q[$]; // expected read data, oldest first
	int err_total = 0; // mismatches
	int check_count = 0; // comparisons

	sgc_global_ctrl #(.PERIOD_100_CYCLES(PERIOD)) u_dut (
		.clock_i(clock_i),
		.reset_i(reset_i),
		.reg_req_i(reg_req),
		.reg_rdata_o(reg_rdata),
		.reg_rvalid_o(reg_rvalid),
		.feature_o(feature),
		.port5_mac_link_o(link),
		.storm_limit_o(limit),
		.storm_block_i(blocks),
		.port_rate_10_mbit_i(rates),
		.storm_drop_o(drop)
	);

	// free running 100 MHz clock
	always #5 clock_i = ~clock_i;

	// compare one value and count it
	task automatic check(input logic [10:0] seen, input logic [10:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// print counts and verdict, then stop
	task automatic final_report();
		$display("checks=%0d mismatches=%0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// one-cycle write strobe
	task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
		@(posedge clock_i);
		reg_req <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
		@(posedge clock_i);
		reg_req.wr <= 1'b0;
	endtask

	// one-cycle read strobe, expected data noted for the monitor
	task automatic reg_read(input logic [7:0] addr, input logic [7:0] exp);
		exp_q.push_back(exp);
		@(posedge clock_i);
		reg_req <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
		@(posedge clock_i);
		reg_req.rd <= 1'b0;
	endtask

	// monitor: each read answer takes the oldest note
	always @(posedge clock_i) begin
		if (!reset_i && reg_rvalid === 1'b1) begin
			if (exp_q.size() == 0) begin
				check(11'(reg_rdata), 11'h7FF);
			end else begin
				check(11'(reg_rdata), 11'(exp_q.pop_front()));
			end
		end
	end

	// watchdog cuts a hang short
	initial begin
		#200000;
		err_total++;
		final_report();
	end

	// main sequence
	initial begin
		logic [7:0] f;
		logic [7:0] l;
		logic [7:0] s;
		logic [4:0] prev;
		logic [4:0] slow;
		int falls[5];
		logic ok;
		void'($urandom(32'h3cd0_1771));
		repeat (6) @(posedge clock_i);
		reset_i <= 1'b0;
		// reset values
		@(negedge clock_i);
		check(limit, 11'h04A);
		check(11'(feature), 11'h000);
		check(11'(link), 11'h000);
		reg_read(`SGC_ADDR_FEATURE, 8'h00);
		reg_read(`SGC_ADDR_LINK, 8'h00);
		reg_read(`SGC_ADDR_STORM_LO, 8'h4A);
		$display("test reset values done");
		// random register contents reach the control outputs
		for (int i = 0; i < 8; i++) begin
			f = 8'($urandom);
			l = 8'($urandom);
			s = 8'($urandom);
			if (i == 0) begin
				f = 8'hFF;
				l = 8'hFF;
			end
			reg_write(`SGC_ADDR_FEATURE, f); // no vlan table in this bench to load first
			reg_write(`SGC_ADDR_LINK, l);
			reg_write(`SGC_ADDR_STORM_LO, s);
			reg_write(8'h08, 8'($urandom));
			@(negedge clock_i);
			check(11'(feature), 11'({f[7], f[6], f[0]}));
			check(11'(link), 11'(l[7:3]));
			check(limit, {l[2:0], s});
			reg_read(`SGC_ADDR_FEATURE, f & `SGC_FEAT_WMASK);
			reg_read(`SGC_ADDR_LINK, l);
			reg_read(`SGC_ADDR_STORM_LO, s);
			reg_read(8'h08, 8'h00);
		end
		reg_read(8'h04, 8'h00);
		repeat (3) @(posedge clock_i);
		check(11'(exp_q.size()), 11'h000);
		$display("test register map done");
		// storm periods: ports 1, 3 and 5 slow, others fast, continuous blocks
		reg_write(`SGC_ADDR_LINK, 8'h10);
		reg_write(`SGC_ADDR_STORM_LO, 8'h03);
		rates <= 4'b0101;
		slow = 5'b10101;
		foreach (falls[p]) falls[p] = 0;
		@(posedge clock_i);
		blocks <= 5'h1F;
		prev = '0;
		repeat (400) begin
			@(posedge clock_i);
			for (int p = 0; p < 5; p++) begin
				if (prev[p] === 1'b1 && drop[p] === 1'b0) begin
					falls[p]++;
				end
			end
			prev = drop;
		end
		blocks <= '0;
		for (int p = 0; p < 5; p++) begin
			ok = slow[p] ? (falls[p] >= 1 && falls[p] <= 3) : (falls[p] >= 19 && falls[p] <= 21);
			check(11'(ok), 11'h001);
		end
		repeat (210) @(posedge clock_i);
		@(negedge clock_i);
		check(11'(drop), 11'h000);
		$display("test storm periods done");
		// second reset in mid-run
		reg_write(`SGC_ADDR_FEATURE, 8'hC1);
		@(posedge clock_i);
		reset_i <= 1'b1;
		repeat (2) @(posedge clock_i);
		reset_i <= 1'b0;
		@(negedge clock_i);
		check(limit, 11'h04A);
		check(11'(feature), 11'h000);
		$display("test second reset done");
		final_report();
	end
endmodule

// File: sgc_pkg.sv
// types shared by the global control bank and its storm meters
package sgc_pkg;

	// one register port request, same clock as the bank
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sgc_reg_req_t;

	// switch-wide feature enables
	typedef struct packed {
		logic vlan_en;
		logic igmp_snoop;
		logic sniff_both;
	} sgc_feature_t;

	// port five mac link settings
	typedef struct packed {
		logic back_pressure;
		logic half_duplex;
		logic flow_ctrl;
		logic rate_10_mbit;
		logic null_vid_replace;
	} sgc_port5_mac_link_t;

endpackage

// File: sgc_storm_meter.sv
// per-port broadcast storm block counter with period restart
`include "sgc_consts.svh"

module sgc_storm_meter (
	// clock and reset
	input wire logic clock_i,
	input wire logic reset_i,
	// period and traffic
	input wire logic period_tick_i,
	input wire logic block_i,
	input wire logic [`SGC_LIMIT_W-1:0] limit_i,
	// result
	output logic drop_o
);
	import sgc_pkg::*;

	logic [`SGC_LIMIT_W-1:0] count_reg; // blocks seen this period
	logic [`SGC_LIMIT_W-1:0] count_next;
	logic drop_reg; // limit reached, discard regulated traffic

	// next count: restart at each period, saturate at the top
	always_comb begin
		count_next = count_reg;
		if (period_tick_i) begin
			count_next = {{(`SGC_LIMIT_W-1){1'b0}}, block_i};
		end else if (block_i && count_reg != `SGC_LIMIT_MAX) begin
			count_next = count_reg + 11'h001;
		end
	end

	// count register
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			count_reg <= '0;
		end else begin
			count_reg <= count_next;
		end
	end

	// drop flag once the count meets the limit
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			drop_reg <= 1'b0;
		end else begin
			drop_reg <= (count_next >= limit_i);
		end
	end

	assign drop_o = drop_reg;

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (reset_i);

	a_count_restart: assert property (
		period_tick_i |=> count_reg <= 11'h001)
		else $error("storm count not restarted at period");

	a_drop_at_limit: assert property (
		!period_tick_i && block_i && count_reg + 11'h001 == limit_i && count_reg != `SGC_LIMIT_MAX
		&& $stable(limit_i) |=> drop_o)
		else $error("drop not raised when limit reached");
endmodule
